// ==== rcr_defs.svh ====
// Summary of operation
// - keyed command write with bit 0 set resets the processor
// - keyed command write with bit 2 set resets the peripherals
// - keyed command write with bit 3 set drives the reset pin low
// - command and mode writes need 0xa5 in the top byte, else discarded
// - status bit 0 shows a pin falling edge since the last status read
// - three-bit cause field: general, wake-up, watchdog, software, user
// - reading status leaves the cause field unchanged
// - cause field resets to 1 after main-only power-up, 0 after backup power-up
// - status bit 16 shows the reset pin level sampled on the clock
// - status bit 17 is high while a software reset runs
// - mode bit 0 set lets a low pin level start a user reset
// - mode bit 4 raises the interrupt on the edge flag if user reset is off
// - pin pulse lasts two to the power of (mode bits 11:8 plus one) ticks
// - reading status clears the edge flag and its interrupt
// - command writes are ignored while a software reset is busy
// - a software reset lasts two slow clock cycles, then busy clears
// - software cause is recorded only when the processor bit was set
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

// register byte offsets
`define RCR_OFF_CMD 5'h00
`define RCR_OFF_STATUS 5'h04
`define RCR_OFF_MODE 5'h08
`define RCR_OFF_EVENT 5'h0c
`define RCR_OFF_MASK 5'h10

// password
`define RCR_KEY 8'ha5
`define RCR_KEY_LSB 24

// command fields
`define RCR_CMD_CPU 0
`define RCR_CMD_PERIPH 2
`define RCR_CMD_PIN 3

// status fields
`define RCR_ST_FALL 0
`define RCR_ST_CAUSE_LSB 8
`define RCR_ST_LEVEL 16
`define RCR_ST_BUSY 17

// mode fields
`define RCR_MD_PIN_EN 0
`define RCR_MD_IRQ_EN 4
`define RCR_MD_LEN_LSB 8

// reset values and timing
`define RCR_MODE_RST 32'h0000_0000
`define RCR_EVT_RST 3'h0
`define RCR_SW_RESET_TICKS 2'h2

`endif

// ==== rcr_pin_model.sv ====
`timescale 1ns/1ps
module rcr_pin_model #(
    parameter int SLOW_HALF = 100
) (
    output logic slow_clk,
    input wire logic pin_oe,
    input wire logic pin_out,
    input wire logic ext_low,
    output logic pin_level
);
    // permanent slow clock, free running, phase unrelated to the master clock
    initial begin
        slow_clk = 1'b0;
        #3;
        forever #(SLOW_HALF) slow_clk = ~slow_clk;
    end

    // reset wire with pull-up: any party pulling low wins
    assign pin_level = ~ext_low & ~(pin_oe & ~pin_out);
endmodule : rcr_pin_model

// ==== rcr_pin_mon.sv ====
`timescale 1ns/1ps
module rcr_pin_mon (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic level_q,
    output logic fall
);
    logic prev_q;

    // pin sampled on every rising clock edge, idle level high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            level_q <= pin_in;
            prev_q <= level_q;
        end
    end

    // high-to-low transition of the sampled level
    assign fall = prev_q & ~level_q;

    a_fall_edge: assert property (
        @(posedge clk) disable iff (!rst_n)
        fall |-> $past(level_q) && !level_q)
        else $error("fall pulse without a falling sample");
endmodule : rcr_pin_mon

// ==== rcr_pkg.sv ====
package rcr_pkg;

    // reset cause codes as reported in status
    typedef enum logic [2:0] {
        CAUSE_GENERAL = 3'h0,
        CAUSE_WAKEUP = 3'h1,
        CAUSE_WATCHDOG = 3'h2,
        CAUSE_SOFTWARE = 3'h3,
        CAUSE_USER = 3'h4
    } rcr_cause_e;

    // reset sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SW,
        ST_USER
    } rcr_state_e;

    typedef logic [31:0] rcr_word_t;

endpackage : rcr_pkg

// ==== rcr_pulse_gen.sv ====
`timescale 1ns/1ps
module rcr_pulse_gen #(
    parameter int LEN_W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic tick,
    input wire logic [LEN_W-1:0] len,
    output logic active_q,
    output logic done
);
    localparam int CNT_W = (1 << LEN_W) + 1;
    logic [CNT_W-1:0] one_w;
    logic [CNT_W-1:0] last_q;
    logic [CNT_W-1:0] cnt_q;

    assign one_w = CNT_W'(1);
    // ends on the tick that completes the programmed count
    assign done = active_q && tick && (cnt_q == last_q);

    // pulse length is captured at start, later mode writes do not stretch it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            cnt_q <= '0;
            last_q <= '0;
        end else if (start && !active_q) begin
            active_q <= 1'b1;
            cnt_q <= '0;
            last_q <= (one_w << ({1'b0, len} + (LEN_W+1)'(1))) - one_w;
        end else if (done) begin
            active_q <= 1'b0;
        end else if (active_q && tick) begin
            cnt_q <= cnt_q + one_w;
        end
    end

    a_pulse_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        active_q && !(tick && cnt_q == last_q) |=> active_q)
        else $error("pin pulse ended before its length");
endmodule : rcr_pulse_gen

// ==== rcr_top.sv ====
`timescale 1ns/1ps
`include "rcr_defs.svh"
module rcr_top
    import rcr_pkg::*;
#(
    parameter int LEN_W = 4
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SLOW_CLK,
    input wire logic MAIN_ONLY_POWERUP,
    input wire logic WDOG_FAULT,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic PIN_RST_IN,
    output logic PIN_RST_OUT,
    output logic PIN_RST_OE,
    output logic CPU_RESET_N,
    output logic PERIPH_RESET_N,
    output logic IRQ
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    rcr_state_e state_q;
    rcr_cause_e cause_q;
    logic ack_q;
    logic wr_go;
    logic rd_go;
    logic key_ok;
    logic cmd_go;
    logic mode_wr;
    logic status_rd;
    logic slow_q;
    logic tick;
    logic [1:0] sw_cnt_q;
    logic sw_end;
    logic cpu_req_q;
    logic per_req_q;
    logic init_q;
    logic fall_q;
    logic [31:0] mode_q;
    logic [2:0] evt_q;
    logic [2:0] mask_q;
    logic [2:0] evt_set;
    logic pin_level;
    logic pin_fall;
    logic pulse_active;
    logic pulse_done;
    logic pulse_guard_q;
    logic user_start;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic [1:0] chk_ticks_q;
    default clocking cb_chk @(posedge CLK); endclocking // checks on CLK
    default disable iff (!RESET_N);

    // true when the written word carries the password
    function automatic logic key_match(input logic [31:0] w);
        return w[`RCR_KEY_LSB +: 8] == `RCR_KEY;
    endfunction : key_match

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then the access completes
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
    assign wr_go = AVS_WRITE & ack_q;
    assign rd_go = AVS_READ & ack_q;
    assign key_ok = key_match(AVS_WRITEDATA);
    assign status_rd = rd_go && (AVS_ADDRESS == `RCR_OFF_STATUS);
    assign mode_wr = wr_go && (AVS_ADDRESS == `RCR_OFF_MODE) && key_ok;
    // command accepted only when idle and at least one action bit set
    assign cmd_go = wr_go && (AVS_ADDRESS == `RCR_OFF_CMD) && key_ok
        && (state_q == ST_IDLE)
        && (AVS_WRITEDATA[`RCR_CMD_CPU] || AVS_WRITEDATA[`RCR_CMD_PERIPH]
        || AVS_WRITEDATA[`RCR_CMD_PIN]);

    // acknowledge toggles so back-to-back requests each see one wait cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
        end
    end

    // read mux, reserved bits and unmapped offsets read zero
    always_comb begin
        rdata_d = '0;
        case (AVS_ADDRESS)
            `RCR_OFF_STATUS: begin
                rdata_d[`RCR_ST_FALL] = fall_q;
                rdata_d[`RCR_ST_CAUSE_LSB +: 3] = cause_q;
                rdata_d[`RCR_ST_LEVEL] = pin_level;
                rdata_d[`RCR_ST_BUSY] = (state_q == ST_SW);
            end
            `RCR_OFF_MODE: rdata_d = mode_q;
            `RCR_OFF_EVENT: rdata_d[2:0] = evt_q;
            `RCR_OFF_MASK: rdata_d[2:0] = mask_q;
            default: rdata_d = '0;
        endcase
    end

    // read data captured in the wait cycle and held through completion
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_q <= '0;
        end else if (AVS_READ && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end
    assign AVS_READDATA = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // mode register, keyed, only defined fields stored
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_q <= `RCR_MODE_RST;
        end else if (mode_wr) begin
            mode_q <= '0;
            mode_q[`RCR_MD_PIN_EN] <= AVS_WRITEDATA[`RCR_MD_PIN_EN];
            mode_q[`RCR_MD_IRQ_EN] <= AVS_WRITEDATA[`RCR_MD_IRQ_EN];
            mode_q[`RCR_MD_LEN_LSB +: LEN_W] <=
                AVS_WRITEDATA[`RCR_MD_LEN_LSB +: LEN_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slow clock rising edge as a tick in the master clock domain
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            slow_q <= 1'b0;
        end else begin
            slow_q <= SLOW_CLK;
        end
    end
    assign tick = SLOW_CLK & ~slow_q;

    ////////////////////////////////////////////////////////////////////////
    // pin sampling and pulse generation
    rcr_pin_mon u_pin_mon (
        .clk(CLK),
        .rst_n(RESET_N),
        .pin_in(PIN_RST_IN),
        .level_q(pin_level),
        .fall(pin_fall)
    );

    rcr_pulse_gen #(.LEN_W(LEN_W)) u_pulse (
        .clk(CLK),
        .rst_n(RESET_N),
        .start(cmd_go && AVS_WRITEDATA[`RCR_CMD_PIN]),
        .tick(tick),
        .len(mode_q[`RCR_MD_LEN_LSB +: LEN_W]),
        .active_q(pulse_active),
        .done(pulse_done)
    );

    // open-drain pin, only ever pulled low
    assign PIN_RST_OUT = 1'b0;
    assign PIN_RST_OE = pulse_active;

    // own pulse, plus the sampling lag after it, never starts a user reset
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pulse_guard_q <= 1'b0;
        end else begin
            pulse_guard_q <= pulse_active;
        end
    end
    assign user_start = mode_q[`RCR_MD_PIN_EN] && !pin_level
        && !pulse_active && !pulse_guard_q;

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer
    assign sw_end = (state_q == ST_SW) && tick
        && (sw_cnt_q == `RCR_SW_RESET_TICKS - 2'h1);

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
            sw_cnt_q <= '0;
            cpu_req_q <= 1'b0;
            per_req_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sw_cnt_q <= '0;
                    if (cmd_go) begin
                        state_q <= ST_SW;
                        cpu_req_q <= AVS_WRITEDATA[`RCR_CMD_CPU];
                        per_req_q <= AVS_WRITEDATA[`RCR_CMD_PERIPH];
                    end else if (user_start) begin
                        state_q <= ST_USER;
                    end
                end
                ST_SW: begin
                    if (sw_end) begin
                        state_q <= ST_IDLE;
                        cpu_req_q <= 1'b0;
                        per_req_q <= 1'b0;
                    end else if (tick) begin
                        sw_cnt_q <= sw_cnt_q + 2'h1;
                    end
                end
                ST_USER: begin
                    if (pin_level) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // reset outputs from flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CPU_RESET_N <= 1'b1;
            PERIPH_RESET_N <= 1'b1;
        end else begin
            CPU_RESET_N <= !((state_q == ST_SW && cpu_req_q)
                || state_q == ST_USER);
            PERIPH_RESET_N <= !((state_q == ST_SW && per_req_q)
                || state_q == ST_USER);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset cause, power-up strap caught on the first edge after release
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            init_q <= 1'b0;
            cause_q <= CAUSE_GENERAL;
        end else begin
            init_q <= 1'b1;
            if (!init_q) begin
                cause_q <= MAIN_ONLY_POWERUP ? CAUSE_WAKEUP
                    : CAUSE_GENERAL;
            end else if (WDOG_FAULT) begin
                cause_q <= CAUSE_WATCHDOG;
            end else if (sw_end && cpu_req_q) begin
                cause_q <= CAUSE_SOFTWARE;
            end else if (state_q == ST_USER && pin_level) begin
                cause_q <= CAUSE_USER;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin edge flag, cleared only by a read that returned it set
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fall_q <= 1'b0;
        end else if (pin_fall) begin
            fall_q <= 1'b1;
        end else if (status_rd && rdata_q[`RCR_ST_FALL]) begin
            fall_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event status: sw reset done, pin pulse done, user reset done
    assign evt_set = {state_q == ST_USER && pin_level, pulse_done, sw_end};

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            evt_q <= `RCR_EVT_RST;
        end else if (wr_go && AVS_ADDRESS == `RCR_OFF_EVENT) begin
            evt_q <= (evt_q & ~AVS_WRITEDATA[2:0]) | evt_set;
        end else begin
            evt_q <= evt_q | evt_set;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mask_q <= `RCR_EVT_RST;
        end else if (wr_go && AVS_ADDRESS == `RCR_OFF_MASK) begin
            mask_q <= AVS_WRITEDATA[2:0];
        end
    end

    // interrupt level
    assign IRQ = (fall_q && mode_q[`RCR_MD_IRQ_EN]
        && !mode_q[`RCR_MD_PIN_EN]) || |(evt_q & mask_q);

    ////////////////////////////////////////////////////////////////////////
    // checks
    // slow ticks seen in the current software reset, apart from sw_cnt_q
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            chk_ticks_q <= 2'h0;
        end else begin
            chk_ticks_q <= (state_q != ST_SW) ? 2'h0
                : chk_ticks_q + {1'b0, tick};
        end
    end

    sequence s_cmd_taken;
        cmd_go ##1 (state_q == ST_SW);
    endsequence
    a_cmd_enter: assert property (cmd_go |-> s_cmd_taken)
        else $error("accepted command did not start a software reset");
    a_bad_key: assert property (
        wr_go && !key_ok && state_q == ST_IDLE && !user_start
        |=> state_q == ST_IDLE && !$rose(pulse_active))
        else $error("write with wrong password took effect");
    a_mode_key: assert property (
        wr_go && AVS_ADDRESS == `RCR_OFF_MODE && !key_ok
        |=> $stable(mode_q))
        else $error("mode changed without password");
    a_busy_ignore: assert property (
        wr_go && state_q == ST_SW && !sw_end
        |=> $stable(cpu_req_q) && $stable(per_req_q))
        else $error("command accepted while busy");
    a_sw_len: assert property (
        state_q == ST_SW && tick
        |=> (state_q == ST_IDLE) == (chk_ticks_q == 2'h2))
        else $error("software reset length wrong");
    a_cause_sw: assert property (
        sw_end && cpu_req_q && !WDOG_FAULT |=> cause_q == CAUSE_SOFTWARE)
        else $error("software cause not recorded");
    a_cause_read: assert property (
        status_rd && init_q && !WDOG_FAULT && !sw_end
        && state_q != ST_USER |=> $stable(cause_q))
        else $error("status read changed the cause");
    a_read_clr: assert property (
        status_rd && rdata_q[`RCR_ST_FALL] && !pin_fall
        |=> !fall_q && !(IRQ && !(|(evt_q & mask_q))))
        else $error("status read did not clear edge flag");
    a_irq_edge: assert property (
        fall_q && mode_q[`RCR_MD_IRQ_EN] && !mode_q[`RCR_MD_PIN_EN] |-> IRQ)
        else $error("edge interrupt missing");
    a_user_enter: assert property (
        state_q == ST_IDLE && user_start && !cmd_go
        |=> state_q == ST_USER ##1 !CPU_RESET_N)
        else $error("low pin did not start user reset");
endmodule : rcr_top

// ==== test_rcr_top.sv ====
`timescale 1ns/1ps
`include "rcr_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_rcr_top
    import rcr_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic strap = 1'b0;
    logic wdog = 1'b0;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    rcr_word_t wdata = 32'h0;
    rcr_word_t rdata;
    logic waitreq, pin_out, pin_oe, cpu_n, per_n, irq, slow_clk, pin_lvl;
    logic ext_low = 1'b0;
    int fails = 0;
    int n_compared = 0;
    int cpu_cnt, per_cnt, oe_cnt;
    rcr_word_t q;

    ////////////////////////////////////////////////////////////////////////
    // clock, design and far side
    always #5 clk = ~clk;

    rcr_top #(.LEN_W(4)) dut (
        .CLK(clk), .RESET_N(reset_n), .SLOW_CLK(slow_clk),
        .MAIN_ONLY_POWERUP(strap), .WDOG_FAULT(wdog),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .PIN_RST_IN(pin_lvl),
        .PIN_RST_OUT(pin_out), .PIN_RST_OE(pin_oe), .CPU_RESET_N(cpu_n),
        .PERIPH_RESET_N(per_n), .IRQ(irq)
    );

    rcr_pin_model #(.SLOW_HALF(100)) far (
        .slow_clk(slow_clk), .pin_oe(pin_oe), .pin_out(pin_out),
        .ext_low(ext_low), .pin_level(pin_lvl)
    );

    // cycles each reset output spends active
    always @(posedge clk) begin
        if (cpu_n === 1'b0) cpu_cnt++;
        if (per_n === 1'b0) per_cnt++;
        if (pin_oe === 1'b1) oe_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus master and helpers
    // waits as long as the slave asks; only the hang guard ends a hang
    task automatic bus(input logic w, input logic [4:0] a, input rcr_word_t d);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wreg(input logic [4:0] a, input rcr_word_t d);
        bus(1'b1, a, d);
    endtask : wreg

    task automatic rreg(input logic [4:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rreg

    // poll status until the busy flag drops
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            rreg(`RCR_OFF_STATUS);
            if (q[17] === 1'b0) break;
        end
    endtask : wait_idle

    task automatic clr();
        cpu_cnt = 0;
        per_cnt = 0;
        oe_cnt = 0;
    endtask : clr

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset(input logic s);
        reset_n <= 1'b0;
        strap <= s;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        rreg(`RCR_OFF_STATUS);
        `CHK(q[10:8], s ? CAUSE_WAKEUP : CAUSE_GENERAL)
        `CHK(q[17:16], 2'h1)
        `CHK(q & ~32'h0003_0701, 32'h0)
        $display("done reset %0d", s);
    endtask : t_reset

    task automatic t_mode();
        wreg(`RCR_OFF_MODE, 32'h5aff_ffff);
        rreg(`RCR_OFF_MODE);
        `CHK(q, 32'h0)
        wreg(`RCR_OFF_MODE, 32'ha5ff_ffff);
        rreg(`RCR_OFF_MODE);
        `CHK(q, 32'h0000_0f11)
        wreg(`RCR_OFF_MODE, 32'ha500_0000);
        wreg(5'h14, 32'hffff_ffff);
        rreg(5'h14);
        `CHK(q, 32'h0)
        $display("done mode");
    endtask : t_mode

    task automatic t_refused();
        clr();
        wreg(`RCR_OFF_CMD, 32'h5a00_000d);
        wreg(`RCR_OFF_CMD, 32'ha500_0000);
        rreg(`RCR_OFF_STATUS);
        `CHK(q[17], 1'b0)
        `CHK(cpu_cnt + per_cnt + oe_cnt, 0)
        $display("done refused");
    endtask : t_refused

    task automatic t_wdog_periph();
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        rreg(`RCR_OFF_STATUS);
        `CHK(q[10:8], CAUSE_WATCHDOG)
        clr();
        wreg(`RCR_OFF_CMD, 32'ha500_0004);
        wait_idle();
        `CHK(per_cnt >= 20 && per_cnt <= 42, 1'b1)
        `CHK(cpu_cnt, 0)
        `CHK(q[10:8], CAUSE_WATCHDOG)
        $display("done periph");
    endtask : t_wdog_periph

    task automatic t_cpu();
        clr();
        wreg(`RCR_OFF_CMD, 32'ha500_0001);
        rreg(`RCR_OFF_STATUS);
        `CHK(q[17], 1'b1)
        wreg(`RCR_OFF_CMD, 32'ha500_0004);
        wait_idle();
        `CHK(q[17], 1'b0)
        `CHK(q[10:8], CAUSE_SOFTWARE)
        `CHK(per_cnt, 0)
        `CHK(cpu_cnt >= 20 && cpu_cnt <= 42, 1'b1)
        $display("done cpu");
    endtask : t_cpu

    task automatic t_pin();
        int lo, hi;
        for (int len = 0; len < 4; len += 2) begin
            lo = (2 ** (len + 1) - 1) * 20;
            hi = 2 ** (len + 1) * 20 + 2;
            wreg(`RCR_OFF_MODE, 32'ha500_0001 | (len << 8));
            clr();
            wreg(`RCR_OFF_CMD, 32'ha500_0008);
            for (int i = 0; i < 200 && pin_oe !== 1'b0; i++) @(posedge clk);
            repeat (2) @(posedge clk);
            `CHK(oe_cnt >= lo && oe_cnt <= hi, 1'b1)
            `CHK(cpu_cnt, 0)
            rreg(`RCR_OFF_STATUS);
            `CHK(q[0], 1'b1)
            rreg(`RCR_OFF_STATUS);
            `CHK(q[0], 1'b0)
        end
        wreg(`RCR_OFF_MODE, 32'ha500_0000);
        $display("done pin");
    endtask : t_pin

    task automatic t_irq();
        wreg(`RCR_OFF_MODE, 32'ha500_0010);
        clr();
        ext_low <= 1'b1;
        for (int i = 0; i < 10 && irq !== 1'b1; i++) @(posedge clk);
        `CHK(irq, 1'b1)
        rreg(`RCR_OFF_STATUS);
        `CHK(q[16], 1'b0)
        `CHK(q[0], 1'b1)
        `CHK(irq, 1'b0)
        ext_low <= 1'b0;
        wreg(`RCR_OFF_MODE, 32'ha500_0000);
        ext_low <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(irq, 1'b0)
        `CHK(cpu_cnt, 0)
        ext_low <= 1'b0;
        rreg(`RCR_OFF_STATUS);
        $display("done irq");
    endtask : t_irq

    task automatic t_user();
        wreg(`RCR_OFF_MODE, 32'ha500_0011);
        ext_low <= 1'b1;
        for (int i = 0; i < 10 && cpu_n !== 1'b0; i++) @(posedge clk);
        `CHK(cpu_n, 1'b0)
        `CHK(irq, 1'b0)
        repeat (30) @(posedge clk);
        ext_low <= 1'b0;
        for (int i = 0; i < 200 && cpu_n !== 1'b1; i++) @(posedge clk);
        `CHK(cpu_n, 1'b1)
        rreg(`RCR_OFF_STATUS);
        `CHK(q[10:8], CAUSE_USER)
        rreg(`RCR_OFF_STATUS);
        `CHK(q[10:8], CAUSE_USER)
        wreg(`RCR_OFF_MODE, 32'ha500_0000);
        $display("done user");
    endtask : t_user

    task automatic t_events();
        rreg(`RCR_OFF_EVENT);
        `CHK(q, 32'h7)
        `CHK(irq, 1'b0)
        wreg(`RCR_OFF_MASK, 32'h2);
        `CHK(irq, 1'b1)
        wreg(`RCR_OFF_EVENT, 32'h2);
        `CHK(irq, 1'b0)
        rreg(`RCR_OFF_EVENT);
        `CHK(q, 32'h5)
        wreg(`RCR_OFF_EVENT, 32'h5);
        rreg(`RCR_OFF_EVENT);
        `CHK(q, 32'h0)
        $display("done events");
    endtask : t_events

    ////////////////////////////////////////////////////////////////////////
    // main sequence and hang guard
    initial begin
        t_reset(1'b0);
        t_reset(1'b1);
        t_mode();
        t_refused();
        t_wdog_periph();
        t_cpu();
        t_pin();
        t_irq();
        t_user();
        t_events();
        stop_test();
    end

    initial begin
        #200us;
        fails++;
        $display("[FAIL] %0t run took too long", $time);
        stop_test();
    end
endmodule : test_rcr_top
